// File: sim/rsc_strap_board.sv
`timescale 1ns/100ps
module rsc_strap_board
(
	input  wire [15:0] pullup_in,
	output wire [15:0] pins_out
);
	// Open pins sink to zero through the pull-downs
	assign pins_out = pullup_in;
endmodule // rsc_strap_board

// File: sim/rsc_strap_capture_bench.sv
`timescale 1ns/100ps
module rsc_strap_capture_bench;
	reg         ref_clk_in = 0, rst_n_in = 0, ext = 0, split = 0;
	reg  [15:0] pull = 16'h0000;
	reg  [15:0] pat [0:3];
	wire [15:0] pins, oe, word, hword, baddr;
	wire [6:0]  ha;
	wire [4:0]  npins;
	wire [2:0]  mode;
	wire        pb, tw, crst, dsel, dval, baud, osc, bext;
	integer     err_count = 0, n_compared = 0, cyc = 0, i;
	always #25 ref_clk_in = ~ref_clk_in;
	rsc_strap_board brd (.pullup_in(pull), .pins_out(pins));
	rsc_strap_capture uut (.ref_clk_in, .rst_n_in, .strap_pins_in(pins),
		.pins_ext_drive_in(ext), .cpu_run_bit_in(split), .clk_stable_in(ext),
		.cpu_split_bit_in(split), .sig_bytes_in({~split, 31'h09ab_cdef}),
		.addr_pins_oe_out(oe), .strap_word_out(word),
		.host_strap_word_out(hword), .host_slave_addr_out(ha),
		.host_twowire_en_out(tw), .debug_pair_sel_out(dsel),
		.embedded_cpu_rst_out(crst), .debug_pair_valid_out(dval),
		.baud_fast_out(baud), .refclk_src_sel_out(osc),
		.progmem_mode_out(mode), .ext_addr_pins_out(npins),
		.boot_external_out(bext), .boot_addr_out(baddr),
		.panel_bias_out(pb));
	task chk(input [15:0] seen, exp, input [95:0] nm);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			err_count = err_count + 1;
			$display("[ERR] %0s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task wrap_up;
	begin
		if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	end
	endtask
	always @(posedge ref_clk_in)
	begin
		cyc = cyc + 1;
		if (cyc == 100)
		begin
			err_count = err_count + 1;
			wrap_up;
		end
	end
	initial
	begin
		pat[0] = 16'h0000;
		pat[1] = 16'hcc33;
		pat[2] = 16'h7ba5;
		pat[3] = 16'h855a;
		for (i = 0; i < 4; i = i + 1)
		begin
			@(posedge ref_clk_in) rst_n_in <= 1'b0;
			pull <= pat[i];
			split <= i[1];
			ext <= i[0];
			repeat (2) @(posedge ref_clk_in);
			#1 chk(oe, 16'h0000, "oe");
			@(posedge ref_clk_in) rst_n_in <= 1'b1;
			@(posedge ref_clk_in) pull <= ~pat[i];
			repeat (3) @(posedge ref_clk_in);
			#1 chk(word, pat[i], "word");
			chk(hword, pat[i], "host word");
			chk(oe, {16{i[0]}}, "oe run");
			chk(ha, pat[i][6:0], "addr");
			chk(tw, !pat[i][8:7], "twowire");
			chk(crst, pat[i][9] ? !i[0] : !i[1], "cpu rst");
			chk(dsel, pat[i][12], "pair sel");
			chk(dval, !pat[i][14], "pair ok");
			chk(baud, !pat[i][11:10], "baud");
			chk(osc, pat[i][13], "osc");
			chk(mode, pat[i][14] ? (i[1] ? 4 : 2) : 1, "mode");
			chk(npins, pat[i][14] ? (i[1] ? 14 : 16) : 0, "pins");
			chk(bext, !pat[i][14] && !i[1], "boot ext");
			chk(baddr, 16'h0000, "boot addr");
			chk(pb, pat[i][15], "bias");
		end
		wrap_up;
	end
endmodule // rsc_strap_capture_bench

// File: sim/rsc_strap_sva.sv
`timescale 1ns/100ps
module rsc_strap_sva
(
	input wire        ref_clk_in, rst_n_in, host_twowire_en_out,
	input wire        baud_fast_out, panel_bias_out, debug_pair_sel_out,
	input wire        embedded_cpu_rst_out, cpu_run_bit_in, clk_stable_in,
	input wire        debug_pair_valid_out, refclk_src_sel_out,
	input wire [15:0] strap_pins_in, strap_word_out, host_strap_word_out,
	input wire [15:0] addr_pins_oe_out,
	input wire [6:0]  host_slave_addr_out,
	input wire [4:0]  ext_addr_pins_out,
	input wire [2:0]  progmem_mode_out
);
	wire [15:0] s = strap_word_out;
	reg  [1:0]  cnt;
	reg  [15:0] cap;
	// Settled after two edges past release; the count stops at three
	always @(posedge ref_clk_in)
	begin
		cnt <= !rst_n_in ? 2'h0 : cnt + {1'b0, cnt != 2'h3};
		if (rst_n_in && cnt == 2'h0) cap <= strap_pins_in;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_word_capture: assert property (cnt == 2'h3 |-> s == cap)
		else $error("word capture");
	a_word_hold: assert property (cnt == 2'h3 |-> $stable(s))
		else $error("word moved");
	a_host_copy: assert property (cnt == 2'h3 |-> host_strap_word_out == s)
		else $error("host word");
	a_slave_addr: assert property (cnt[1] |-> host_slave_addr_out == s[6:0])
		else $error("slave addr");
	a_twowire_en: assert property (cnt[1] |-> host_twowire_en_out == !s[8:7])
		else $error("twowire");
	a_baud_code: assert property (cnt[1] |-> baud_fast_out == !s[11:10])
		else $error("baud");
	a_bias_pol: assert property (cnt[1] |-> panel_bias_out == s[15])
		else $error("bias");
	a_debug_pair: assert property (cnt[1] |-> debug_pair_sel_out == s[12])
		else $error("debug pair");
	a_pins_input: assert property (cnt == 2'h1 |-> addr_pins_oe_out == 16'h0000)
		else $error("pins driven early");
	a_cpu_reset: assert property (cnt == 2'h3 |->
		embedded_cpu_rst_out == (s[9] ? !$past(clk_stable_in)
		: !$past(cpu_run_bit_in)))
		else $error("cpu reset");
	a_pair_valid: assert property (cnt[1] |-> debug_pair_valid_out == !s[14])
		else $error("pair valid");
	a_clk_source: assert property (cnt[1] |-> refclk_src_sel_out == s[13])
		else $error("clock source");
	a_mem_internal: assert property (cnt[1] && !s[14] |->
		progmem_mode_out == 3'b001 && ext_addr_pins_out == 5'h00)
		else $error("memory layout");
endmodule // rsc_strap_sva
bind rsc_strap_capture rsc_strap_sva chk (.ref_clk_in, .rst_n_in,
	.host_twowire_en_out, .baud_fast_out, .panel_bias_out, .debug_pair_sel_out,
	.embedded_cpu_rst_out, .cpu_run_bit_in, .clk_stable_in,
	.debug_pair_valid_out, .refclk_src_sel_out, .addr_pins_oe_out,
	.ext_addr_pins_out, .progmem_mode_out,
	.strap_pins_in, .strap_word_out, .host_strap_word_out, .host_slave_addr_out);

// File: verilog/rsc_strap_capture.v
// Operation
// (RL1) While hardware reset is low, all sixteen shared address pins are inputs.
// (RL2) On reset release the sixteen pin levels are latched as the strap word.
// (RL3) The strap word is readable by the embedded cpu and the serial host port.
// (RL4) Undriven pins read zero through pull-downs, pulled-up pins read one.
// (RL5) Strap bits 6:0 give the 7-bit two-wire slave address.
// (RL6) The board straps bits 7 and 8 low to enable the two-wire host port.
// (RL7) The board should leave bit 8 open when host pins carry the debug channel.
// (RL8) Bit 9 low holds the cpu in reset until a control bit frees it; high runs (the code holds reset until clk_stable_in is high).
// (RL9) Bit 12 picks the debug pin pair, only when bit 14 is low.
// (RL10) Bits 11:10 code 00 gives 115.2 KBaud, any other code 57.6 KBaud.
// (RL11) Bit 13 low means crystal reference, high means single-ended oscillator.
// (RL12) Bit 14 with control bit 4 picks internal, external or split memory.
// (RL13) Internal boot checks a four-byte signature at 0xFFFC and jumps to 0x0000.
// (RL14) Bit 15 sets the panel bias level driven after reset.
// (RL15) The strap word holds until the next reset release; strap_word_out and host_strap_word_out clear to 0000 while reset is low.
`timescale 1ns/100ps
`include "rsc_strap_map.vh"
module rsc_strap_capture
#(
	parameter STRAP_W = `RSC_STRAP_W
)
(
	input  wire               ref_clk_in,
	input  wire               rst_n_in,
	input  wire [STRAP_W-1:0] strap_pins_in,
	input  wire               pins_ext_drive_in,
	input  wire               cpu_run_bit_in,
	input  wire               cpu_split_bit_in,
	input  wire               clk_stable_in,
	input  wire [31:0]        sig_bytes_in,
	output reg  [STRAP_W-1:0] addr_pins_oe_out,
	output reg  [STRAP_W-1:0] strap_word_out,
	output reg  [STRAP_W-1:0] host_strap_word_out,
	output reg  [6:0]         host_slave_addr_out,
	output reg                host_twowire_en_out,
	output reg                embedded_cpu_rst_out,
	output reg                debug_pair_sel_out,
	output reg                debug_pair_valid_out,
	output reg                baud_fast_out,
	output reg                refclk_src_sel_out,
	output reg  [2:0]         progmem_mode_out,
	output reg  [4:0]         ext_addr_pins_out,
	output reg                boot_external_out,
	output reg  [15:0]        boot_addr_out,
	output reg                panel_bias_out
);
	// Hold in reset, latch on the first clock after release, then run
	localparam [2:0] ST_HOLD  = 3'b001;
	localparam [2:0] ST_LATCH = 3'b010;
	localparam [2:0] ST_RUN   = 3'b100;

	reg  [2:0]         state;
	reg  [2:0]         next_state;
	wire [STRAP_W-1:0] strap;
	wire               capture;
	wire               loaded;
	wire               cpu_autorun;
	wire               progmem_layout_sel;
	wire [1:0]         baud_sel;
	wire [31:0]        sig_expect;
	wire               sig_ok;

	reg  [STRAP_W-1:0] next_oe;
	reg  [6:0]         next_slave_addr;
	reg                next_twowire_en;
	reg                next_cpu_rst;
	reg                next_pair_sel;
	reg                next_pair_valid;
	reg                next_baud_fast;
	reg                next_refclk_sel;
	reg  [2:0]         next_mode;
	reg  [4:0]         next_ext_pins;
	reg                next_boot_ext;
	reg                next_bias;

	assign capture            = rst_n_in & (state == ST_HOLD);
	assign loaded             = (state == ST_LATCH) | (state == ST_RUN);
	assign cpu_autorun        = strap[`RSC_AUTORUN_BIT];
	assign progmem_layout_sel = strap[`RSC_LAYOUT_BIT];
	assign baud_sel           = {strap[`RSC_BAUD_HI_BIT],
		strap[`RSC_BAUD_LO_BIT]};
	assign sig_expect         = {`RSC_SIG_B0, `RSC_SIG_B1,
		`RSC_SIG_B2, `RSC_SIG_B3};
	assign sig_ok             = (sig_bytes_in == sig_expect);

	always @*
	begin
		next_state = state;
		case (state)
			ST_HOLD:  next_state = ST_LATCH;
			ST_LATCH: next_state = ST_RUN;
			ST_RUN:   next_state = ST_RUN;
			default:  next_state = ST_HOLD;
		endcase
	end

	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			state <= ST_HOLD;
		else
			state <= next_state;
	end

	// No reset here, so the word survives until the next release
	genvar g;
	generate
		for (g = 0; g < STRAP_W; g = g + 1)
		begin : g_strap_bit
			reg bit_q;
			always @(posedge ref_clk_in)
			begin
				if (capture)
					bit_q <= strap_pins_in[g]; // RL2 RL4 RL15
			end
			assign strap[g] = bit_q;
		end
	endgenerate

	// Decodes track their inputs every cycle, one clock behind
	always @*
	begin
		next_oe         = {STRAP_W{pins_ext_drive_in}};
		next_slave_addr = strap[`RSC_HOST_ADDR_MSB:
			`RSC_HOST_ADDR_LSB]; // RL5
		// Board-side duty; only decoded here
		next_twowire_en = ~strap[`RSC_HOST_PROT_BIT] &
			~strap[`RSC_HOST_EN_BIT]; // RL6 RL7
		next_cpu_rst    = cpu_autorun ? ~clk_stable_in
			: ~cpu_run_bit_in; // RL8
		next_pair_sel   = strap[`RSC_DBG_PAIR_BIT]; // RL9
		next_pair_valid = ~progmem_layout_sel; // RL9
		next_baud_fast  = (baud_sel == `RSC_BAUD_FAST); // RL10
		next_refclk_sel = strap[`RSC_CLK_SRC_BIT]; // RL11
		if (!progmem_layout_sel)
		begin
			next_mode     = `RSC_MEM_INT; // RL12
			next_ext_pins = 5'h00;
		end
		else if (!cpu_split_bit_in)
		begin
			next_mode     = `RSC_MEM_EXT; // RL12
			next_ext_pins = `RSC_ADDR_PINS_EXT;
		end
		else
		begin
			next_mode     = `RSC_MEM_SPLIT; // RL12
			next_ext_pins = `RSC_ADDR_PINS_SPL;
		end
		// Signature bytes come from the fetch path; no read here
		next_boot_ext   = ~progmem_layout_sel & sig_ok; // RL13
		next_bias       = strap[`RSC_BIAS_POL_BIT]; // RL14
	end

	// Pins drive only once the word is held, never in the capture window
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			addr_pins_oe_out    <= {STRAP_W{1'b0}}; // RL1
			strap_word_out      <= `RSC_STRAP_RST;
			host_strap_word_out <= `RSC_STRAP_RST;
		end
		else if (loaded)
		begin
			addr_pins_oe_out    <= next_oe; // RL1
			strap_word_out      <= strap; // RL3
			host_strap_word_out <= strap; // RL3
		end
	end

	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			host_slave_addr_out <= 7'h00;
			host_twowire_en_out <= 1'b0;
		end
		else if (loaded)
		begin
			host_slave_addr_out <= next_slave_addr; // RL5
			host_twowire_en_out <= next_twowire_en;
		end
	end

	// Cpu stays held through the capture window whatever the strap says
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			embedded_cpu_rst_out <= 1'b1;
			debug_pair_sel_out   <= 1'b0;
			debug_pair_valid_out <= 1'b0;
			baud_fast_out        <= 1'b0;
			refclk_src_sel_out   <= 1'b0;
		end
		else if (loaded)
		begin
			embedded_cpu_rst_out <= next_cpu_rst; // RL8
			debug_pair_sel_out   <= next_pair_sel; // RL9
			debug_pair_valid_out <= next_pair_valid; // RL9
			baud_fast_out        <= next_baud_fast; // RL10
			refclk_src_sel_out   <= next_refclk_sel; // RL11
		end
	end

	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			progmem_mode_out  <= `RSC_MEM_INT;
			ext_addr_pins_out <= 5'h00;
			boot_external_out <= 1'b0;
			boot_addr_out     <= 16'h0000;
			panel_bias_out    <= 1'b0;
		end
		else if (loaded)
		begin
			progmem_mode_out  <= next_mode; // RL12
			ext_addr_pins_out <= next_ext_pins; // RL12
			boot_external_out <= next_boot_ext; // RL13
			boot_addr_out     <= `RSC_EXT_BOOT_ADDR; // RL13
			panel_bias_out    <= next_bias; // RL14
		end
	end
endmodule // rsc_strap_capture

// File: verilog/rsc_strap_map.vh
`ifndef RSC_STRAP_MAP_VH
`define RSC_STRAP_MAP_VH
`define RSC_STRAP_W        16
`define RSC_HOST_ADDR_MSB  6
`define RSC_HOST_ADDR_LSB  0
`define RSC_HOST_PROT_BIT  7
`define RSC_HOST_EN_BIT    8
`define RSC_AUTORUN_BIT    9
`define RSC_BAUD_LO_BIT    10
`define RSC_BAUD_HI_BIT    11
`define RSC_DBG_PAIR_BIT   12
`define RSC_CLK_SRC_BIT    13
`define RSC_LAYOUT_BIT     14
`define RSC_BIAS_POL_BIT   15
`define RSC_STRAP_RST      16'h0000
`define RSC_CPU_CTRL_REG   8'h22
`define RSC_CPU_CTRL_SPLIT 4
`define RSC_BAUD_FAST      2'b00
`define RSC_MEM_INT        3'b001
`define RSC_MEM_EXT        3'b010
`define RSC_MEM_SPLIT      3'b100
`define RSC_ADDR_PINS_EXT  5'h10
`define RSC_ADDR_PINS_SPL  5'h0e
`define RSC_SIG_ADDR       16'hfffc
`define RSC_SIG_B0         8'h89
`define RSC_SIG_B1         8'hab
`define RSC_SIG_B2         8'hcd
`define RSC_SIG_B3         8'hef
`define RSC_EXT_BOOT_ADDR  16'h0000
`endif
